// [core/cgc_pkg.sv]
// shared constants, field layouts and carrier types of the clock generator control block
package cgc_pkg;

    // ************************************************************
    // register map (byte addresses, 32-bit aligned words)
    // ************************************************************
    localparam logic [7:0] OFS_OSC_CTRL = 8'h00;   // oscillator_ctrl_reg
    localparam logic [7:0] OFS_FREQ     = 8'h04;   // freq_measure_reg, read only
    localparam logic [7:0] OFS_PLL_CFG  = 8'h08;   // pll_config_reg
    localparam logic [7:0] OFS_STATUS   = 8'h0c;   // power_status_reg, read only
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;   // power_irq_mask

    // ************************************************************
    // field positions and widths
    // ************************************************************
    localparam int OSC_EN_BIT   = 0;
    localparam int BYPASS_BIT   = 1;
    localparam int CLK_SEL_BIT  = 2;
    localparam int STARTUP_LSB  = 8;
    localparam int STARTUP_W    = 8;
    localparam int FREQ_W       = 16;
    localparam int FREQ_DONE_BIT = 16;
    localparam int DIV_LSB      = 0;
    localparam int DIV_W        = 8;
    localparam int SETTLE_LSB   = 8;
    localparam int SETTLE_W     = 6;
    localparam int GAIN_LSB     = 16;
    localparam int GAIN_W       = 11;
    localparam int STABLE_BIT   = 0;
    localparam int LOCK_BIT     = 1;

    // ************************************************************
    // timing counts, in low-speed clock edges
    // ************************************************************
    localparam logic [2:0] PRE_LAST  = 3'h7;     // start-up counter runs on slow clock / 8
    localparam logic [3:0] LAST_FALL = 4'hf;     // 16th falling edge ends a measurement

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } cgc_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cgc_axi_rsp_t;

    typedef enum logic [1:0] {
        F_IDLE,
        F_WAIT,
        F_COUNT,
        F_DONE
    } cgc_freq_st_t;

    typedef struct packed {
        logic                 aw_have;
        logic [7:0]           aw_addr;
        logic                 w_have;
        logic [31:0]          w_data;
        logic [3:0]           w_strb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
        logic                 osc_en;
        logic                 bypass;
        logic                 clk_sel;
        logic [STARTUP_W-1:0] startup;
        logic [STARTUP_W-1:0] osc_cnt;
        logic                 osc_run;
        logic [2:0]           pre;
        logic                 stable;
        logic [DIV_W-1:0]     div;
        logic [SETTLE_W-1:0]  settle;
        logic [GAIN_W-1:0]    gain;
        logic [SETTLE_W-1:0]  pll_cnt;
        logic                 pll_run;
        logic                 pll_on;
        logic                 lock;
        logic                 mask_stable;
        logic                 mask_lock;
        logic                 irq;
        logic                 slow_prev;
        logic                 xtal_prev;
        cgc_freq_st_t         fst;
        logic [3:0]           nfall;
        logic [FREQ_W-1:0]    fcount;
        logic                 fdone;
    } cgc_state_t;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             out;
    } cgc_div_state_t;

    localparam cgc_state_t     CGC_STATE_RST = '0;
    localparam cgc_div_state_t CGC_DIV_RST   = '0;

endpackage

// [core/cgc_divider.sv]
// programmable input divider feeding the multiplying loop
`timescale 1ns/1ps
module cgc_divider
    import cgc_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic             src_level,
    input  wire logic             src_rise,
    input  wire logic [DIV_W-1:0] div_ratio,
    output logic                  div_out
);

    cgc_div_state_t   q;
    cgc_div_state_t   d;
    logic [DIV_W-1:0] half;

    // ************************************************************
    // divide by div_ratio, high for the first half of each period, rounded up for odd ratios
    // ************************************************************
    always_comb begin
        d    = q;
        half = (div_ratio >> 1) + {7'h00, div_ratio[0]};
        if (div_ratio == 8'h00) begin
            d.cnt = 8'h00;
            d.out = 1'b0;
        end else if (div_ratio == 8'h01) begin
            d.cnt = 8'h00;
            d.out = src_level;
        end else if (src_rise) begin
            d.cnt = (q.cnt >= div_ratio - 8'h01) ? 8'h00 : q.cnt + 8'h01;
            d.out = d.cnt < half;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= CGC_DIV_RST;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign div_out = q.out;

endmodule // cgc_divider

// [core/cgc_top.sv]
// clock generator control: oscillator start-up, frequency meter, loop sequencing, AXI4-Lite
`timescale 1ns/1ps
module cgc_top
    import cgc_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          sys_rst,
    input  wire logic          clk_en,
    input  wire cgc_axi_req_t  axi_req,
    output cgc_axi_rsp_t       axi_rsp,
    input  wire logic          low_speed_clock,
    input  wire logic          crystal_clock,
    input  wire logic          multiplied_clock,
    output logic               xtal_osc_enable,
    output logic               xtal_bypass,
    output logic               pll_enable,
    output logic [GAIN_W-1:0]  pll_gain_factor,
    output logic               pll_ref_clock,
    output logic               pll_out_clock,
    output logic               active_clock,
    output logic               power_irq
);

    cgc_state_t  q;
    cgc_state_t  d;
    logic        slow_rise;
    logic        slow_fall;
    logic        xtal_rise;
    logic        aw_ready;
    logic        w_ready;
    logic        ar_ready;
    logic        do_wr;
    logic        wr_osc;
    logic        wr_pll;
    logic        wr_mask;
    logic        pll_change;
    logic        div_out;
    logic [31:0] osc_view;
    logic [31:0] pll_view;
    logic [31:0] freq_view;
    logic [31:0] stat_view;
    logic [31:0] mask_view;
    logic [31:0] wm_osc;
    logic [31:0] wm_pll;
    logic [31:0] wm_mask;

    function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ************************************************************
    // register views and write decode
    // ************************************************************
    assign osc_view  = {16'h0000, q.startup, 5'h00, q.clk_sel, q.bypass, q.osc_en};
    assign pll_view  = {5'h00, q.gain, 2'h0, q.settle, q.div};
    assign freq_view = {15'h0000, q.fdone, q.fcount};
    assign stat_view = {30'h00000000, q.lock, q.stable};
    assign mask_view = {30'h00000000, q.mask_lock, q.mask_stable};
    assign wm_osc    = wmerge(osc_view, q.w_data, q.w_strb);
    assign wm_pll    = wmerge(pll_view, q.w_data, q.w_strb);
    assign wm_mask   = wmerge(mask_view, q.w_data, q.w_strb);

    // both halves of a write are held before it acts, so aw and w may come in any order
    assign do_wr   = q.aw_have && q.w_have && !q.bvalid;
    assign wr_osc  = do_wr && (q.aw_addr == OFS_OSC_CTRL);
    assign wr_pll  = do_wr && (q.aw_addr == OFS_PLL_CFG);
    assign wr_mask = do_wr && (q.aw_addr == OFS_IRQ_MASK);
    assign pll_change = !q.pll_on || (wm_pll[DIV_LSB +: DIV_W] != q.div)
                      || (wm_pll[SETTLE_LSB +: SETTLE_W] != q.settle)
                      || (wm_pll[GAIN_LSB +: GAIN_W] != q.gain);

    // slow and crystal clocks arrive synchronous; crystal above half ref_clk will alias
    assign slow_rise = low_speed_clock && !q.slow_prev;
    assign slow_fall = !low_speed_clock && q.slow_prev;
    assign xtal_rise = crystal_clock && !q.xtal_prev;

    // a frozen block must not accept transfers it cannot register
    assign aw_ready = clk_en && !q.aw_have && !q.bvalid;
    assign w_ready  = clk_en && !q.w_have && !q.bvalid;
    assign ar_ready = clk_en && !q.rvalid;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        d = q;
        d.slow_prev = low_speed_clock;
        d.xtal_prev = crystal_clock;

        // oscillator start-up countdown on slow clock / 8
        if (q.osc_run && slow_rise) begin
            d.pre = q.pre + 3'h1;
            if (q.pre == PRE_LAST) begin
                if (q.osc_cnt <= 8'h01) begin
                    d.stable  = 1'b1;
                    d.osc_run = 1'b0;
                end else begin
                    d.osc_cnt = q.osc_cnt - 8'h01;
                end
            end
        end

        // frequency meter
        if (!q.stable) begin
            d.fst   = F_IDLE;
            d.fdone = 1'b0;
        end else begin
            case (q.fst)
                F_IDLE: begin
                    d.fst = F_WAIT;
                end
                F_WAIT: begin
                    if (slow_rise) begin
                        d.fst    = F_COUNT;
                        d.fcount = '0;
                        d.nfall  = 4'h0;
                    end
                end
                F_COUNT: begin
                    if (xtal_rise) begin
                        d.fcount = q.fcount + 16'h0001;
                    end
                    if (slow_fall) begin
                        if (q.nfall == LAST_FALL) begin
                            d.fst   = F_DONE;
                            d.fdone = 1'b1;
                        end else begin
                            d.nfall = q.nfall + 4'h1;
                        end
                    end
                end
                F_DONE: begin
                    d.fst = F_DONE;
                end
                default: begin
                    d.fst = F_IDLE;
                end
            endcase
        end

        // loop settle counter on slow clock
        if (q.pll_run && slow_rise) begin
            if (q.pll_cnt <= 6'h01) begin
                d.lock    = 1'b1;
                d.pll_run = 1'b0;
            end else begin
                d.pll_cnt = q.pll_cnt - 6'h01;
            end
        end

        // bus: address and data capture, response retire
        if (axi_req.awvalid && aw_ready) begin
            d.aw_have = 1'b1;
            d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && w_ready) begin
            d.w_have = 1'b1;
            d.w_data = axi_req.wdata;
            d.w_strb = axi_req.wstrb;
        end
        if (q.bvalid && axi_req.bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && axi_req.rready) begin
            d.rvalid = 1'b0;
        end

        // an oscillator control write, or a loop config write that changes it, restarts and overrides the counters above; one that zeroes the gain stops the loop
        if (do_wr) begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = RESP_OKAY;
            case (q.aw_addr)
                OFS_OSC_CTRL: begin
                    d.osc_en  = wm_osc[OSC_EN_BIT];
                    d.bypass  = wm_osc[BYPASS_BIT];
                    d.clk_sel = wm_osc[CLK_SEL_BIT];
                    d.startup = wm_osc[STARTUP_LSB +: STARTUP_W];
                    d.stable  = 1'b0;
                    d.osc_run = wm_osc[OSC_EN_BIT];
                    d.osc_cnt = wm_osc[STARTUP_LSB +: STARTUP_W];
                    d.pre     = 3'h0;
                end
                OFS_PLL_CFG: begin
                    d.div    = wm_pll[DIV_LSB +: DIV_W];
                    d.settle = wm_pll[SETTLE_LSB +: SETTLE_W];
                    d.gain   = wm_pll[GAIN_LSB +: GAIN_W];
                    if (wm_pll[GAIN_LSB +: GAIN_W] == 11'h000) begin
                        d.pll_on  = 1'b0;
                        d.pll_run = 1'b0;
                        d.lock    = 1'b0;
                    end else if (pll_change) begin
                        d.pll_on  = 1'b1;
                        d.pll_run = 1'b1;
                        d.lock    = 1'b0;
                        d.pll_cnt = wm_pll[SETTLE_LSB +: SETTLE_W];
                    end
                end
                OFS_IRQ_MASK: begin
                    d.mask_stable = wm_mask[STABLE_BIT];
                    d.mask_lock   = wm_mask[LOCK_BIT];
                end
                OFS_FREQ, OFS_STATUS: begin
                    d.bresp = RESP_OKAY;
                end
                default: begin
                    d.bresp = RESP_SLVERR;
                end
            endcase
        end

        if (axi_req.arvalid && ar_ready) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            case (axi_req.araddr)
                OFS_OSC_CTRL: d.rdata = osc_view;
                OFS_FREQ:     d.rdata = freq_view;
                OFS_PLL_CFG:  d.rdata = pll_view;
                OFS_STATUS:   d.rdata = stat_view;
                OFS_IRQ_MASK: d.rdata = mask_view;
                default: begin
                    d.rdata = 32'h00000000;
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end

        d.irq = (d.stable && d.mask_stable) || (d.lock && d.mask_lock);
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= CGC_STATE_RST;
        end else if (clk_en) begin
            q <= d;
        end
    end

    // ************************************************************
    // loop divider and outputs
    // ************************************************************
    cgc_divider u_div (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .src_level (crystal_clock),
        .src_rise  (xtal_rise),
        .div_ratio (q.div),
        .div_out   (div_out)
    );

    // gating with the ratio itself keeps both clocks low the cycle a zero lands
    assign pll_ref_clock   = div_out && (q.div != 8'h00);
    assign pll_out_clock   = multiplied_clock && (q.div != 8'h00) && q.pll_on;
    assign pll_gain_factor = q.gain;
    assign pll_enable      = q.pll_on;
    // combinational select: glitch-free switching is left to the clock tree
    assign active_clock    = (q.clk_sel && q.stable) ? crystal_clock : low_speed_clock;
    assign xtal_osc_enable = q.osc_en;
    assign xtal_bypass     = q.bypass;
    assign power_irq       = q.irq;

    assign axi_rsp.awready = aw_ready;
    assign axi_rsp.wready  = w_ready;
    assign axi_rsp.bvalid  = q.bvalid;
    assign axi_rsp.bresp   = q.bresp;
    assign axi_rsp.arready = ar_ready;
    assign axi_rsp.rvalid  = q.rvalid;
    assign axi_rsp.rdata   = q.rdata;
    assign axi_rsp.rresp   = q.rresp;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_osc_start;
        clk_en && wr_osc && wm_osc[OSC_EN_BIT];
    endsequence

    sequence s_pll_restart;
        clk_en && wr_pll && (wm_pll[GAIN_LSB +: GAIN_W] != 11'h000) && pll_change;
    endsequence

    a_reset_state: assert property (
        $fell(sys_rst) |-> !xtal_osc_enable && !q.clk_sel && (q.div == 8'h00))
        else $error("reset state wrong");
    a_osc_off: assert property (
        clk_en && wr_osc && !wm_osc[OSC_EN_BIT] |=> !q.stable && !xtal_osc_enable)
        else $error("disable did not clear stable");
    a_osc_start: assert property (
        s_osc_start |=> !q.stable && q.osc_run
            && (q.osc_cnt == $past(wm_osc[STARTUP_LSB +: STARTUP_W])))
        else $error("start-up not loaded");
    a_startup_hold: assert property (
        clk_en && q.osc_run && !(slow_rise && q.pre == PRE_LAST) && !wr_osc
            |=> $stable(q.osc_cnt) && !q.stable)
        else $error("start-up counter moved off tick");
    a_stable_set: assert property (
        $rose(q.stable) |-> $past(q.osc_run) && ($past(q.osc_cnt) <= 8'h01))
        else $error("stable set early");
    a_freq_begin: assert property (
        clk_en && q.stable && (q.fst == F_WAIT) && slow_rise && !wr_osc
            |=> (q.fst == F_COUNT) && (q.fcount == 16'h0000))
        else $error("count did not start");
    a_freq_stop: assert property (
        clk_en && q.stable && (q.fst == F_COUNT) && slow_fall && (q.nfall == LAST_FALL)
            && !wr_osc |=> q.fdone ##1 $stable(q.fcount))
        else $error("count did not stop");
    a_div_zero: assert property (
        (q.div == 8'h00) |-> !pll_ref_clock && !pll_out_clock)
        else $error("clock not held low");
    a_pll_off: assert property (
        clk_en && wr_pll && (wm_pll[GAIN_LSB +: GAIN_W] == 11'h000) |=> !pll_enable && !q.lock)
        else $error("loop not disabled");
    a_pll_restart: assert property (
        s_pll_restart |=> !q.lock && q.pll_run
            && (q.pll_cnt == $past(wm_pll[SETTLE_LSB +: SETTLE_W])))
        else $error("loop restart wrong");
    a_lock_set: assert property (
        clk_en && q.pll_run && slow_rise && (q.pll_cnt <= 6'h01) && !wr_pll |=> q.lock)
        else $error("lock not set");
    a_irq_out: assert property (
        power_irq == ((q.stable && q.mask_stable) || (q.lock && q.mask_lock)))
        else $error("interrupt mismatch");

endmodule // cgc_top

// [sim/cgc_analog_model.sv]
// stand-in for the analog side: rc slow clock, crystal and loop output
`timescale 1ns/1ps
module cgc_analog_model
    import cgc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic xtal_osc_enable,
    input  wire logic xtal_bypass,
    input  wire logic pll_enable,
    output logic      low_speed_clock,
    output logic      crystal_clock,
    output logic      multiplied_clock
);
    // outputs are settled by the first edge, well inside the reset period
    logic [3:0] ph_q = 4'h0;
    // ***************
    // clock sources
    // ***************
    // slow clock never stops; crystal period 4 cycles keeps it under half the sampling rate
    always @(posedge ref_clk) begin
        ph_q <= ph_q + 4'h1;
        low_speed_clock <= ph_q[3];
        crystal_clock <= (xtal_osc_enable | xtal_bypass) & ph_q[1];
        multiplied_clock <= pll_enable & ph_q[0];
    end
endmodule // cgc_analog_model

// [sim/tb_clock_generator_control.sv]
// self-checking bench for the clock generator control block
`timescale 1ns/1ps
module tb_clock_generator_control;
    import cgc_pkg::*;
    logic              ref_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              clk_en = 1'b1;
    cgc_axi_req_t      req = '0;
    cgc_axi_rsp_t      rsp;
    logic              lsc, xck, mck, osc_en, byp, pll_en, pll_ref, pll_out, act_clk, irq;
    logic [GAIN_W-1:0] gain_o;
    logic [31:0]       rd;
    logic [1:0]        rs;
    int                num_errors = 0;
    int                tests_run = 0;
    int                seed = 32'h84c29e0f;
    int                n, cyc, st, sv, dv, gv, f;

    always #25 ref_clk = ~ref_clk;

    cgc_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .axi_req(req),
        .axi_rsp(rsp), .low_speed_clock(lsc), .crystal_clock(xck), .multiplied_clock(mck),
        .xtal_osc_enable(osc_en), .xtal_bypass(byp), .pll_enable(pll_en),
        .pll_gain_factor(gain_o), .pll_ref_clock(pll_ref), .pll_out_clock(pll_out),
        .active_clock(act_clk), .power_irq(irq));
    cgc_analog_model far (.ref_clk(ref_clk), .xtal_osc_enable(osc_en), .xtal_bypass(byp),
        .pll_enable(pll_en), .low_speed_clock(lsc), .crystal_clock(xck),
        .multiplied_clock(mck));

    // ***************
    // shared tasks
    // ***************
    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic hang();
        num_errors++;
        $display("[FAIL] wait exp done got timeout");
        give_verdict();
    endtask
    // slow clock of the analog model: 16 ref_clk cycles a period
    function automatic int slow_cyc(input int n);
        return n * 16;
    endfunction
    // cycles between two rising edges of the divided reference clock
    task automatic ref_period(output int p);
        int k, e;
        logic pr;
        pr = 1'b1;
        e = 0;
        p = 0;
        for (k = 0; k < 2200 && e < 2; k++) begin
            @(negedge ref_clk);
            if (pll_ref && !pr) e++;
            if (e == 1) p++;
            pr = pll_ref;
        end
        if (e < 2) hang();
    endtask
    // entry edge first, so bready/rready never get two values in one time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        logic ta, tw, tk;
        @(posedge ref_clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        // readies and response are looked at mid-cycle, where they are settled
        for (k = 0; k < 50; k++) begin
            @(negedge ref_clk);
            ta = req.awvalid && rsp.awready;
            tw = req.wvalid && rsp.wready;
            tk = rsp.bvalid;
            rs = rsp.bresp;
            @(posedge ref_clk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (tk) break;
        end
        req.bready <= 1'b0;
        if (k == 50) hang();
    endtask
    task automatic rd_reg(input logic [7:0] a);
        int k;
        logic ta, tk;
        @(posedge ref_clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(negedge ref_clk);
            ta = req.arvalid && rsp.arready;
            tk = rsp.rvalid;
            rd = rsp.rdata;
            rs = rsp.rresp;
            @(posedge ref_clk);
            if (ta) req.arvalid <= 1'b0;
            if (tk) break;
        end
        req.rready <= 1'b0;
        if (k == 50) hang();
    endtask
    task automatic wait_irq();
        for (cyc = 0; cyc < 4000 && irq !== 1'b1; cyc++) @(posedge ref_clk);
        if (cyc == 4000) hang();
    endtask

    // ***************
    // main sequence
    // ***************
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk("act_clk", lsc, act_clk);
        chk("osc_en", 0, osc_en);
        // a frozen block must refuse every transfer
        clk_en <= 1'b0;
        @(negedge ref_clk);
        chk("frozen_rdy", 0, {rsp.awready, rsp.wready, rsp.arready});
        @(posedge ref_clk);
        clk_en <= 1'b1;
        rd_reg(OFS_OSC_CTRL);
        chk("osc_ctrl", 0, rd);
        rd_reg(OFS_PLL_CFG);
        chk("pll_cfg", 0, rd);
        rd_reg(8'h14);
        chk("bad_resp", RESP_SLVERR, rs);
        wr(OFS_IRQ_MASK, 32'h3);
        wr(OFS_OSC_CTRL, 32'hff01);
        rd_reg(OFS_OSC_CTRL);
        chk("startup", 32'hff01, rd);
        // rewrite restarts the long count with a short one
        st = ($random(seed) & 32'h3) + 1;
        wr(OFS_OSC_CTRL, {16'h0, st[7:0], 8'h05});
        wait_irq();
        chk("osc_wait", 1, cyc >= (8 * st - 1) * 16 - 4 && cyc <= 8 * st * 16 + 8);
        for (n = 0; n < 8; n++) begin
            @(negedge ref_clk);
            chk("act_xtal", xck, act_clk);
        end
        for (n = 0; n < 200; n++) begin
            rd_reg(OFS_FREQ);
            if (rd[FREQ_DONE_BIT]) break;
        end
        if (n == 200) hang();
        // rising start to 16th fall spans 15.5 slow periods; crystal period is 4 cycles
        f = slow_cyc(31) / 8;
        chk("freq", 1, rd[15:0] >= f - 1 && rd[15:0] <= f + 1);
        wr(OFS_OSC_CTRL, 32'h2);
        chk("bypass", 1, byp);
        rd_reg(OFS_STATUS);
        chk("stable_off", 0, rd);
        chk("irq_off", 0, irq);
        sv = ($random(seed) & 32'h7) + 2;
        dv = ($random(seed) & 32'hfe) + 1;
        gv = ($random(seed) & 32'h7fe) + 1;
        wr(OFS_PLL_CFG, {5'h0, gv[10:0], 2'h0, sv[5:0], dv[7:0]});
        chk("gain", gv, gain_o);
        chk("pll_en", 1, pll_en);
        wait_irq();
        chk("lock_wait", 1, cyc >= (sv - 1) * 16 - 4 && cyc <= sv * 16 + 8);
        rd_reg(OFS_PLL_CFG);
        chk("pll_cfg", {5'h0, gv[10:0], 2'h0, sv[5:0], dv[7:0]}, rd);
        rd_reg(OFS_STATUS);
        chk("lock", 32'h2, rd);
        ref_period(n);
        chk("ref_period", 4 * dv, n);
        for (n = 0; n < 2; n++) begin
            @(negedge ref_clk);
            chk("pll_out", mck, pll_out);
        end
        wr(OFS_PLL_CFG, {5'h0, gv[10:0], 2'h0, sv[5:0], 8'h00});
        rd_reg(OFS_STATUS);
        chk("lock_clr", 0, rd);
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            chk("div0", 0, {pll_ref, pll_out});
        end
        wr(OFS_PLL_CFG, 32'h0);
        chk("pll_off", 0, pll_en);
        give_verdict();
    end
endmodule // tb_clock_generator_control
